/* File: src/tcd_top.sv */
// Purpose: Transmit six-stage interpolating comb-integrator plus channel delay adjuster
// Assumes: Data producer and sync sources as described at the ports; one clock
// Notes: Notes on behaviour below; register map is in the package
// Notes on behaviour
// - Interpolation ratio programmable from 4 to 32
// - Six 24-bit combs then six integrators
// - Per-stage select bit picks delay two
// - Shifter cuts 50-bit sum to 18 bits
// - Per-signal scale field doubles gain per step
// - Ratio is rate field plus one, codes below 3 clamp to 4, shared
// - Integrator overflow detected, filter flushed automatically
// - Maskable interrupt flags any filter overflow
// - Four disable bits stop auto flush
// - Rising test bit forces an overflow
// - Rising clear bit clears the overflow
// - Wideband mode disables both B filters
// - Each channel pair adds two samples delay
// - Decimate by field plus one rounded down to 1,2,4,8
// - Fine offset shifts decimation phase per clock
// - Fine offset maps to signed clock offsets
// - 64 by 36 memory gives coarse delay
// - Coarse 62 is minus two, 63 minus one
// - Twenty-four locations equalize internal channel delay
// - Selectable syncs align fine and coarse phasing
// - B delay settings act only in narrowband
// - Mode bit enables narrowband and B paths
`timescale 1ns/10ps
module tcd_top #(
	parameter int CHAN_INDEX = 0 // Position of this channel in the sum chain
) (
	input wire logic CLK, // Transmit clock, 10 MHz
	input wire logic RST, // Asynchronous reset, active high
	input wire logic [7:0] ADDRESS, // Avalon byte address
	input wire logic READ, // Avalon read request
	input wire logic WRITE, // Avalon write request
	input wire logic [3:0] BYTEENABLE, // Avalon byte lanes
	input wire logic [31:0] WRITEDATA, // Avalon write data
	output logic [31:0] READDATA, // Avalon read data
	output logic WAITREQUEST, // Avalon stall
	input wire logic [tcd_pkg::TCD_OW-1:0] IN_A_I, // Signal A in-phase sample
	input wire logic [tcd_pkg::TCD_OW-1:0] IN_A_Q, // Signal A quadrature sample
	input wire logic [tcd_pkg::TCD_OW-1:0] IN_B_I, // Signal B in-phase sample
	input wire logic [tcd_pkg::TCD_OW-1:0] IN_B_Q, // Signal B quadrature sample
	output logic IN_TAKE, // Inputs captured at edge where high
	input wire logic [7:0] SYNC_IN, // Asynchronous sync sources
	output logic [tcd_pkg::TCD_OW-1:0] OUT_A_I, // Delayed A in-phase
	output logic [tcd_pkg::TCD_OW-1:0] OUT_A_Q, // Delayed A quadrature
	output logic [tcd_pkg::TCD_OW-1:0] OUT_B_I, // Delayed B in-phase
	output logic [tcd_pkg::TCD_OW-1:0] OUT_B_Q, // Delayed B quadrature
	output logic OUT_VALID_A, // A output sample strobe
	output logic OUT_VALID_B, // B output sample strobe
	output logic IRQ // Masked overflow interrupt
);
	import tcd_pkg::*;

	// Byte-lane merge of a register write
	function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				r[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		return r;
	endfunction

	// Decimation field limited to 1, 2, 4 or 8
	function automatic logic [3:0] dec_factor(input logic [2:0] f);
		logic [3:0] r;
		case (f)
			3'h0: r = 4'h1;
			3'h1, 3'h2: r = 4'h2;
			3'h3, 3'h4, 3'h5, 3'h6: r = 4'h4;
			default: r = 4'h8;
		endcase
		return r;
	endfunction

	// Fine offset to decimation phase; top code means plus one
	function automatic logic [2:0] fine_phase(input logic [2:0] fine, input logic [3:0] fac);
		logic [3:0] r;
		r = 4'h0;
		if (fac != 4'h1) begin
			if ({1'b0, fine} == fac - 4'h1) begin
				r = 4'h1;
			end else if (fine != 3'h0) begin
				r = fac - {1'b0, fine};
			end
		end
		return r[2:0];
	endfunction

	// Coarse offset as a signed delay: 62, 63 wrap to minus two, minus one
	function automatic logic [5:0] coarse_dist(input logic [5:0] c);
		return TCD_EQ_LOCS + 6'(2 * (CHAN_INDEX / 2)) + c;
	endfunction

	// Shift the last integrator down by 31 minus the scale field
	function automatic logic [TCD_IW-1:0] cic_shift(input logic [TCD_IW-1:0] v,
		input logic [4:0] scale);
		return $signed(v) >>> (TCD_SHIFT_TOP - scale);
	endfunction

	// Register file
	logic [31:0] ctrl_ff; // Mode, rate, decimation
	logic [31:0] cic_a_ff; // Scale and delay select, A
	logic [31:0] cic_b_ff; // Scale and delay select, B
	logic [31:0] flush_ff; // Disable, test, clear bits
	logic [31:0] delay_ff; // Coarse and fine offsets
	logic [31:0] sync_ff; // Sync source selects
	logic [3:0] mask_ff; // Interrupt mask
	logic [3:0] ovf_ff; // Sticky overflow flags
	tcd_bus_t bus_ff; // Handshake state
	logic acc_en; // Request accepted this edge
	logic [31:0] rd_mux; // Read data selection

	// Decoded controls
	logic narrow; // Two-signal narrowband mode
	logic [4:0] rate; // Rate field
	logic [3:0] fac; // Decimation factor
	logic [2:0] ph_a; // Decimation phase, A
	logic [2:0] ph_b; // Decimation phase, B
	assign narrow = ctrl_ff[TCD_POS_MODE];
	assign rate = (ctrl_ff[TCD_POS_RATE +: 5] < TCD_RATE_MIN) ? TCD_RATE_MIN
		: ctrl_ff[TCD_POS_RATE +: 5];
	assign fac = dec_factor(ctrl_ff[TCD_POS_DECIM +: 3]);
	assign ph_a = fine_phase(delay_ff[TCD_POS_FIN_A +: 3], fac);
	assign ph_b = narrow ? fine_phase(delay_ff[TCD_POS_FIN_B +: 3], fac) : 3'h0;

	assign acc_en = (READ || WRITE) && (bus_ff == TCD_BUS_ACK);

	// Bus handshake: stall one cycle, then accept
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			bus_ff <= TCD_BUS_IDLE;
			WAITREQUEST <= 1'b1;
		end else if ((READ || WRITE) && bus_ff == TCD_BUS_IDLE) begin
			bus_ff <= TCD_BUS_ACK;
			WAITREQUEST <= 1'b0;
		end else begin
			bus_ff <= TCD_BUS_IDLE;
			WAITREQUEST <= 1'b1;
		end
	end

	// Read multiplexer; unmapped reads return zero
	always_comb begin
		case (ADDRESS & 8'hFC)
			TCD_OFS_CTRL: rd_mux = ctrl_ff;
			TCD_OFS_CIC_A: rd_mux = cic_a_ff;
			TCD_OFS_CIC_B: rd_mux = cic_b_ff;
			TCD_OFS_FLUSH: rd_mux = flush_ff;
			TCD_OFS_DELAY: rd_mux = delay_ff;
			TCD_OFS_SYNC: rd_mux = sync_ff;
			TCD_OFS_STATUS: rd_mux = {27'h0, |(ovf_ff & mask_ff), ovf_ff};
			TCD_OFS_MASK: rd_mux = {28'h0, mask_ff};
			default: rd_mux = 32'h0;
		endcase
	end

	// Read data registered at the stall cycle, stands through acceptance
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			READDATA <= 32'h0;
		end else if (READ && bus_ff == TCD_BUS_IDLE) begin
			READDATA <= rd_mux;
		end
	end

	// Register writes at the accepting edge
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			ctrl_ff <= TCD_RST_CTRL;
			cic_a_ff <= TCD_RST_ZERO;
			cic_b_ff <= TCD_RST_ZERO;
			flush_ff <= TCD_RST_ZERO;
			delay_ff <= TCD_RST_ZERO;
			sync_ff <= TCD_RST_ZERO;
			mask_ff <= 4'h0;
		end else if (acc_en && WRITE) begin
			case (ADDRESS & 8'hFC)
				TCD_OFS_CTRL: ctrl_ff <= be_merge(ctrl_ff, WRITEDATA, BYTEENABLE);
				TCD_OFS_CIC_A: cic_a_ff <= be_merge(cic_a_ff, WRITEDATA, BYTEENABLE);
				TCD_OFS_CIC_B: cic_b_ff <= be_merge(cic_b_ff, WRITEDATA, BYTEENABLE);
				TCD_OFS_FLUSH: flush_ff <= be_merge(flush_ff, WRITEDATA, BYTEENABLE);
				TCD_OFS_DELAY: delay_ff <= be_merge(delay_ff, WRITEDATA, BYTEENABLE);
				TCD_OFS_SYNC: sync_ff <= be_merge(sync_ff, WRITEDATA, BYTEENABLE);
				TCD_OFS_MASK: mask_ff <= 4'(be_merge({28'h0, mask_ff}, WRITEDATA, BYTEENABLE));
				default: ;
			endcase
		end
	end

	// Sync inputs: two-flop synchroniser, then an edge stage
	logic [7:0] sync_m_ff; // First stage, read only by the second
	logic [7:0] sync_s_ff; // Synchronised level
	logic [7:0] sync_d_ff; // Previous synchronised level
	logic [7:0] sync_rise; // Rising edges
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			sync_m_ff <= 8'h0;
			sync_s_ff <= 8'h0;
			sync_d_ff <= 8'h0;
		end else begin
			sync_m_ff <= SYNC_IN;
			sync_s_ff <= sync_m_ff;
			sync_d_ff <= sync_s_ff;
		end
	end
	assign sync_rise = sync_s_ff & ~sync_d_ff;
	logic sy_cic; // Selected comb-integrator sync
	logic sy_fine; // Selected fine sync
	logic sy_crs; // Selected coarse sync
	assign sy_cic = sync_rise[sync_ff[TCD_POS_SS_CIC +: 3]];
	assign sy_fine = sync_rise[sync_ff[TCD_POS_SS_FIN +: 3]];
	assign sy_crs = sync_rise[sync_ff[TCD_POS_SS_CRS +: 3]];

	// Interpolation phase counter; IN_TAKE once per ratio
	logic [4:0] ip_cnt_ff; // Counts 0 .. rate
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			ip_cnt_ff <= 5'h0;
			IN_TAKE <= 1'b0;
		end else if (sy_cic || ip_cnt_ff >= rate) begin
			ip_cnt_ff <= 5'h0;
			IN_TAKE <= 1'b1;
		end else begin
			ip_cnt_ff <= ip_cnt_ff + 5'h1;
			IN_TAKE <= 1'b0;
		end
	end

	// Filter state
	logic [TCD_CW-1:0] comb_d1_ff [TCD_NFILT][TCD_NSTAGE]; // Comb delay one
	logic [TCD_CW-1:0] comb_d2_ff [TCD_NFILT][TCD_NSTAGE]; // Comb delay two
	logic [TCD_IW-1:0] integ_ff [TCD_NFILT][TCD_NSTAGE]; // Integrators
	logic [TCD_CW-1:0] comb_in [TCD_NFILT][TCD_NSTAGE]; // Stage inputs
	logic [TCD_CW-1:0] comb_out [TCD_NFILT]; // Last comb output
	logic [TCD_IW-1:0] shifted [TCD_NFILT]; // Shifter outputs
	logic [TCD_OW-1:0] in_smp [TCD_NFILT]; // Input samples
	logic [TCD_NFILT-1:0] f_on; // Filter enabled
	logic [TCD_NFILT-1:0] err; // Overflow event this cycle
	logic [TCD_NFILT-1:0] flush_now_ff; // Flush pulse
	logic [TCD_NFILT-1:0] test_d_ff; // Previous test bits
	logic [TCD_NFILT-1:0] clr_d_ff; // Previous clear bits
	logic [TCD_NFILT-1:0] test_rise; // Rising test bits
	logic [TCD_NFILT-1:0] clr_rise; // Rising clear bits
	assign in_smp[0] = IN_A_I;
	assign in_smp[1] = IN_A_Q;
	assign in_smp[2] = IN_B_I;
	assign in_smp[3] = IN_B_Q;
	assign f_on = {narrow, narrow, 2'b11};
	assign test_rise = flush_ff[TCD_POS_FTEST +: 4] & ~test_d_ff;
	assign clr_rise = flush_ff[TCD_POS_FCLR +: 4] & ~clr_d_ff;

	// Comb chain at the input rate; bit k selects delay two for stage k
	always_comb begin
		for (int f = 0; f < TCD_NFILT; f++) begin
			comb_in[f][0] = TCD_CW'($signed(in_smp[f]));
			for (int s = 1; s < TCD_NSTAGE; s++) begin
				comb_in[f][s] = comb_in[f][s-1] - (((f < 2) ? cic_a_ff[TCD_POS_DDSEL + s - 1]
					: cic_b_ff[TCD_POS_DDSEL + s - 1]) ? comb_d2_ff[f][s-1]
					: comb_d1_ff[f][s-1]);
			end
			comb_out[f] = comb_in[f][5] - (((f < 2) ? cic_a_ff[TCD_POS_DDSEL + 5]
				: cic_b_ff[TCD_POS_DDSEL + 5]) ? comb_d2_ff[f][5] : comb_d1_ff[f][5]);
			shifted[f] = cic_shift(integ_ff[f][5], (f < 2) ? cic_a_ff[TCD_POS_SCALE +: 5]
				: cic_b_ff[TCD_POS_SCALE +: 5]);
			err[f] = f_on[f] && ((shifted[f][TCD_IW-1:TCD_OW-1] != '0
				&& shifted[f][TCD_IW-1:TCD_OW-1] != '1) || test_rise[f]);
		end
	end

	// Comb and integrator registers; flush or disable zeroes them
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			for (int f = 0; f < TCD_NFILT; f++) begin
				for (int s = 0; s < TCD_NSTAGE; s++) begin
					comb_d1_ff[f][s] <= '0;
					comb_d2_ff[f][s] <= '0;
					integ_ff[f][s] <= '0;
				end
			end
		end else begin
			for (int f = 0; f < TCD_NFILT; f++) begin
				for (int s = 0; s < TCD_NSTAGE; s++) begin
					if (flush_now_ff[f] || !f_on[f]) begin
						comb_d1_ff[f][s] <= '0;
						comb_d2_ff[f][s] <= '0;
						integ_ff[f][s] <= '0;
					end else begin
						if (IN_TAKE) begin
							comb_d1_ff[f][s] <= comb_in[f][s];
							comb_d2_ff[f][s] <= comb_d1_ff[f][s];
						end
						if (s == 0) begin
							integ_ff[f][s] <= integ_ff[f][s] + (IN_TAKE
								? TCD_IW'($signed(comb_out[f])) : '0);
						end else begin
							integ_ff[f][s] <= integ_ff[f][s] + integ_ff[f][s-1];
						end
					end
				end
			end
		end
	end

	// Overflow flags, flush pulse and edge history
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			ovf_ff <= 4'h0;
			flush_now_ff <= 4'h0;
			test_d_ff <= 4'h0;
			clr_d_ff <= 4'h0;
		end else begin
			ovf_ff <= err | (ovf_ff & ~clr_rise);
			flush_now_ff <= err & ~flush_ff[TCD_POS_FDIS +: 4];
			test_d_ff <= flush_ff[TCD_POS_FTEST +: 4];
			clr_d_ff <= flush_ff[TCD_POS_FCLR +: 4];
		end
	end

	// Interrupt output
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			IRQ <= 1'b0;
		end else begin
			IRQ <= |(ovf_ff & mask_ff);
		end
	end

	// Decimation counter at the transmit clock
	logic [2:0] dec_cnt_ff; // Counts 0 .. fac-1
	logic stb_a; // A decimation moment
	logic stb_b; // B decimation moment
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			dec_cnt_ff <= 3'h0;
		end else if (sy_fine || {1'b0, dec_cnt_ff} >= fac - 4'h1) begin
			dec_cnt_ff <= 3'h0;
		end else begin
			dec_cnt_ff <= dec_cnt_ff + 3'h1;
		end
	end
	assign stb_a = (dec_cnt_ff == ph_a);
	assign stb_b = narrow && (dec_cnt_ff == ph_b);

	// Coarse delay memories and pointers
	logic [2*TCD_OW-1:0] mem_a [TCD_MEM_DEPTH]; // A delay memory
	logic [2*TCD_OW-1:0] mem_b [TCD_MEM_DEPTH]; // B delay memory
	logic [TCD_MEM_AW-1:0] wp_a_ff; // A write pointer
	logic [TCD_MEM_AW-1:0] wp_b_ff; // B write pointer
	logic [TCD_MEM_AW-1:0] rp_a; // A read pointer
	logic [TCD_MEM_AW-1:0] rp_b; // B read pointer
	assign rp_a = wp_a_ff - coarse_dist(delay_ff[TCD_POS_CRS_A +: 6]);
	assign rp_b = wp_b_ff - coarse_dist(delay_ff[TCD_POS_CRS_B +: 6]);

	// Write pointers advance per output sample; coarse sync realigns
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			wp_a_ff <= '0;
			wp_b_ff <= '0;
		end else if (sy_crs) begin
			wp_a_ff <= '0;
			wp_b_ff <= '0;
		end else begin
			if (stb_a) begin
				wp_a_ff <= wp_a_ff + 6'h1;
			end
			if (stb_b) begin
				wp_b_ff <= wp_b_ff + 6'h1;
			end
		end
	end

	// Memory writes of decimated filter output, no reset on storage
	always_ff @(posedge CLK) begin
		if (stb_a) begin
			mem_a[wp_a_ff] <= {shifted[0][TCD_OW-1:0], shifted[1][TCD_OW-1:0]};
		end
		if (stb_b) begin
			mem_b[wp_b_ff] <= {shifted[2][TCD_OW-1:0], shifted[3][TCD_OW-1:0]};
		end
	end

	// Delayed outputs
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			{OUT_A_I, OUT_A_Q, OUT_B_I, OUT_B_Q} <= '0;
			OUT_VALID_A <= 1'b0;
			OUT_VALID_B <= 1'b0;
		end else begin
			OUT_VALID_A <= stb_a;
			OUT_VALID_B <= stb_b;
			if (stb_a) begin
				{OUT_A_I, OUT_A_Q} <= mem_a[rp_a];
			end
			if (stb_b) begin
				{OUT_B_I, OUT_B_Q} <= mem_b[rp_b];
			end else if (!narrow) begin
				{OUT_B_I, OUT_B_Q} <= '0;
			end
		end
	end

	// Checks
	AST_TAKE_SPACING: assert property (@(posedge CLK) disable iff (RST)
		IN_TAKE && !sy_cic |=> !IN_TAKE [*3]) else $error("take pulses too close");
	AST_FLUSH_ZERO: assert property (@(posedge CLK) disable iff (RST)
		flush_now_ff[0] |=> integ_ff[0][5] == '0 && comb_d1_ff[0][0] == '0)
		else $error("flush left state");
	AST_OVF_SET: assert property (@(posedge CLK) disable iff (RST)
		err[1] |=> ovf_ff[1]) else $error("overflow not flagged");
	AST_FLUSH_DIS: assert property (@(posedge CLK) disable iff (RST)
		err[0] && flush_ff[TCD_POS_FDIS] |=> !flush_now_ff[0]) else $error("disabled flush ran");
	AST_IRQ: assert property (@(posedge CLK) disable iff (RST)
		(ovf_ff & mask_ff) != 4'h0 |=> IRQ) else $error("interrupt missing");
	AST_TEST: assert property (@(posedge CLK) disable iff (RST)
		$rose(flush_ff[TCD_POS_FTEST]) |-> ##1 ovf_ff[0]) else $error("test edge ignored");
	AST_CLEAR: assert property (@(posedge CLK) disable iff (RST)
		clr_rise[0] && !err[0] |=> !ovf_ff[0]) else $error("clear edge ignored");
	AST_WIDE_B: assert property (@(posedge CLK) disable iff (RST)
		!narrow [*2] |-> !OUT_VALID_B && err[3:2] == 2'b00) else $error("B path active in wideband");
	AST_BUS: assert property (@(posedge CLK) disable iff (RST)
		(READ || WRITE) && WAITREQUEST |=> !WAITREQUEST ##1 WAITREQUEST)
		else $error("bus answer timing");
	AST_DEC8: assert property (@(posedge CLK) disable iff (RST || sy_fine)
		fac == 4'h8 && stb_a && $stable(ctrl_ff) |=> !stb_a [*7]) else $error("decimation period");
endmodule // tcd_top

/* File: common/tcd_pkg.sv */
// Purpose: Shared constants for the transmit comb-integrator and delay adjuster
// Assumes: Avalon-MM byte addresses, 32-bit data, one word per register
// Notes: Every offset, field position, count and reset value except the mask's lives here
package tcd_pkg;
	// Register byte offsets
	localparam logic [7:0] TCD_OFS_CTRL = 8'h00;
	localparam logic [7:0] TCD_OFS_CIC_A = 8'h04;
	localparam logic [7:0] TCD_OFS_CIC_B = 8'h08;
	localparam logic [7:0] TCD_OFS_FLUSH = 8'h0C;
	localparam logic [7:0] TCD_OFS_DELAY = 8'h10;
	localparam logic [7:0] TCD_OFS_SYNC = 8'h14;
	localparam logic [7:0] TCD_OFS_STATUS = 8'h18;
	localparam logic [7:0] TCD_OFS_MASK = 8'h1C;
	// Field positions (low bit of each field)
	localparam int TCD_POS_MODE = 0;
	localparam int TCD_POS_RATE = 8;
	localparam int TCD_POS_DECIM = 16;
	localparam int TCD_POS_SCALE = 0;
	localparam int TCD_POS_DDSEL = 8;
	localparam int TCD_POS_FDIS = 0;
	localparam int TCD_POS_FTEST = 8;
	localparam int TCD_POS_FCLR = 16;
	localparam int TCD_POS_CRS_A = 0;
	localparam int TCD_POS_CRS_B = 8;
	localparam int TCD_POS_FIN_A = 16;
	localparam int TCD_POS_FIN_B = 20;
	localparam int TCD_POS_SS_CIC = 0;
	localparam int TCD_POS_SS_FIN = 4;
	localparam int TCD_POS_SS_CRS = 8;
	// Reset values
	localparam logic [31:0] TCD_RST_CTRL = 32'h0000_0300;
	localparam logic [31:0] TCD_RST_ZERO = 32'h0000_0000;
	// Structure sizes
	localparam int TCD_NFILT = 4;
	localparam int TCD_NSTAGE = 6;
	localparam int TCD_CW = 24;
	localparam int TCD_IW = 50;
	localparam int TCD_OW = 18;
	localparam int TCD_MEM_DEPTH = 64;
	localparam int TCD_MEM_AW = 6;
	localparam logic [4:0] TCD_SHIFT_TOP = 5'h1F;
	localparam logic [5:0] TCD_EQ_LOCS = 6'h18;
	localparam logic [4:0] TCD_RATE_MIN = 5'h03;
	// Bus handshake states
	typedef enum logic [0:0] {
		TCD_BUS_IDLE = 1'b0,
		TCD_BUS_ACK = 1'b1
	} tcd_bus_t;
endpackage

/* File: tb/tcd_src_model.sv */
// Purpose: Upstream filter stage model that feeds sample pairs to the block
// Assumes: Block captures all four inputs at the edge where take is high
// Notes: Small random amplitude keeps the integrators clear of overflow
`timescale 1ns/10ps
module tcd_src_model (
	input wire logic clk, // Transmit clock
	input wire logic rst, // Reset, active high
	input wire logic take, // Capture strobe from the block
	output logic [tcd_pkg::TCD_OW-1:0] a_i, // Signal A in-phase
	output logic [tcd_pkg::TCD_OW-1:0] a_q, // Signal A quadrature
	output logic [tcd_pkg::TCD_OW-1:0] b_i, // Signal B in-phase
	output logic [tcd_pkg::TCD_OW-1:0] b_q // Signal B quadrature
);
	import tcd_pkg::*;
	int seed = 1378; // Fixed seed so every run repeats
	// Present a new sample set after each capture edge, held until the next
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			a_i <= '0;
			a_q <= '0;
			b_i <= '0;
			b_q <= '0;
		end else if (take) begin
			a_i <= TCD_OW'($random(seed) % 256);
			a_q <= TCD_OW'($random(seed) % 256);
			b_i <= TCD_OW'($random(seed) % 256);
			b_q <= TCD_OW'($random(seed) % 256);
		end
	end
endmodule // tcd_src_model

/* File: tb/testbench.sv */
// Purpose: Self-checking bench for the comb-integrator and delay adjuster
// Assumes: Avalon slave answers after one wait cycle; sync inputs held low
// Notes: Overflow flags are modelled with integers and compared on each status read of the overflow scenario
`timescale 1ns/10ps
module testbench;
	import tcd_pkg::*;
	logic CLK = 1'b0; // Transmit clock
	logic RST = 1'b1; // Reset, active high
	logic [7:0] ADDRESS = 8'h00; // Bus address
	logic READ = 1'b0; // Bus read
	logic WRITE = 1'b0; // Bus write
	logic [3:0] BYTEENABLE = 4'hF; // Byte lanes
	logic [31:0] WRITEDATA = 32'h0; // Bus write data
	logic [7:0] SYNC_IN = 8'h00; // Sync sources held quiet
	wire logic [31:0] READDATA; // Bus read data
	wire logic WAITREQUEST; // Bus stall
	wire logic [TCD_OW-1:0] ai, aq, bi, bq, oai, oaq, obi, obq; // Sample buses
	wire logic IN_TAKE, OUT_VALID_A, OUT_VALID_B, IRQ; // Strobes
	int n_errors = 0; // Mismatch count
	int n_checks = 0; // Comparison count
	int cyc = 0; // Cycles since start
	int seed = 1378; // Fixed seed for register data
	logic [31:0] q; // Last read word
	logic [31:0] wd; // Random word written in the readback scenario
	int rates[5] = '{0, 3, 7, 19, 31}; // Rate field codes under test
	int decs[4] = '{0, 1, 3, 7}; // Decimation field codes under test
	int fines[2] = '{3, 7}; // Decimation codes for the fine phase scenario
	int n, k, c, f, ovf, msk; // Loop variables and flag model

	always #50 CLK = ~CLK;

	tcd_top i_dut (.CLK(CLK), .RST(RST), .ADDRESS(ADDRESS), .READ(READ), .WRITE(WRITE),
		.BYTEENABLE(BYTEENABLE), .WRITEDATA(WRITEDATA), .READDATA(READDATA),
		.WAITREQUEST(WAITREQUEST), .IN_A_I(ai), .IN_A_Q(aq), .IN_B_I(bi), .IN_B_Q(bq),
		.IN_TAKE(IN_TAKE), .SYNC_IN(SYNC_IN), .OUT_A_I(oai), .OUT_A_Q(oaq), .OUT_B_I(obi),
		.OUT_B_Q(obq), .OUT_VALID_A(OUT_VALID_A), .OUT_VALID_B(OUT_VALID_B), .IRQ(IRQ));
	tcd_src_model i_src (.clk(CLK), .rst(RST), .take(IN_TAKE), .a_i(ai), .a_q(aq), .b_i(bi),
		.b_q(bq));

	// Verdict and end of run
	task automatic end_of_test;
		if (n_errors == 0 && n_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	// Compare a bus or pin value
	task automatic chk_reg(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask

	// Compare a cycle count measured by the bench
	task automatic chk_gap(input string what, input int exp, input int got);
		n_checks++;
		if (got != exp) begin
			n_errors++;
			$display("[FAIL] %s expected %0d seen %0d", what, exp, got);
		end
	endtask

	// One Avalon transfer, held until waitrequest is sampled low
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int w;
		@(posedge CLK);
		ADDRESS <= a;
		WRITEDATA <= d;
		WRITE <= wr;
		READ <= !wr;
		w = 0;
		do begin
			@(posedge CLK);
			w++;
		end while (WAITREQUEST !== 1'b0 && w < 50);
		q = READDATA;
		WRITE <= 1'b0;
		READ <= 1'b0;
		if (w >= 50) begin
			n_errors++;
			end_of_test();
		end
	endtask

	// Strobe selector for the gap measurement
	function automatic logic sig(input int s);
		case (s)
			0: return IN_TAKE;
			1: return OUT_VALID_A;
			default: return OUT_VALID_B;
		endcase
	endfunction

	// Cycles between two successive pulses of one strobe
	task automatic gap(input int s, output int g);
		int w;
		w = 0;
		while (sig(s) !== 1'b1 && w < 200) begin
			@(posedge CLK);
			w++;
		end
		g = 0;
		do begin
			@(posedge CLK);
			g++;
		end while (sig(s) !== 1'b1 && g < 200);
	endtask

	// Cycles from an A output pulse to the next B output pulse
	task automatic lag(output int g);
		int w;
		w = 0;
		while (OUT_VALID_A !== 1'b1 && w < 50) begin
			@(posedge CLK);
			w++;
		end
		g = 0;
		while (OUT_VALID_B !== 1'b1 && g < 50) begin
			@(posedge CLK);
			g++;
		end
	endtask

	// Writable bits of the plain control words
	function automatic logic [31:0] rw_mask(input int i);
		case (i)
			0, 1, 2, 3, 4: return 32'hFFFF_FFFF;
			default: return 32'h0000_000F;
		endcase
	endfunction

	// Offsets matching the mask table
	function automatic logic [7:0] ofs_of(input int i);
		case (i)
			0: return TCD_OFS_CTRL;
			1: return TCD_OFS_CIC_A;
			2: return TCD_OFS_CIC_B;
			3: return TCD_OFS_DELAY;
			4: return TCD_OFS_SYNC;
			default: return TCD_OFS_MASK;
		endcase
	endfunction

	// Hang guard
	always @(posedge CLK) begin
		cyc++;
		if (cyc >= 20000) begin
			n_errors++;
			end_of_test();
		end
	end

	// Main sequence
	initial begin
		repeat (12) @(posedge CLK);
		RST <= 1'b0;
		// Reset contents of every mapped word
		for (k = 0; k < 8; k++) begin
			bus(1'b0, 8'(4 * k), 32'h0);
			chk_reg("reset word", (k == 0) ? TCD_RST_CTRL : TCD_RST_ZERO, q);
		end
		// Unmapped place and read-only status ignore writes
		bus(1'b1, 8'h20, $random(seed));
		bus(1'b0, 8'h20, 32'h0);
		chk_reg("unmapped", 32'h0, q);
		bus(1'b1, TCD_OFS_STATUS, 32'hFFFF_FFFF);
		bus(1'b0, TCD_OFS_STATUS, 32'h0);
		chk_reg("status ro", 32'h0, q);
		// Random readback of control words
		for (k = 0; k < 6; k++) begin
			wd = $random(seed);
			bus(1'b1, ofs_of(k), wd);
			bus(1'b0, ofs_of(k), 32'h0);
			chk_reg("readback", wd & rw_mask(k), q);
			bus(1'b1, ofs_of(k), 32'h0);
		end
		// Input period follows the rate field, low codes clamp to ratio 4
		for (k = 0; k < 5; k++) begin
			c = rates[k];
			bus(1'b1, TCD_OFS_CTRL, 32'(c) << TCD_POS_RATE);
			repeat (40) @(posedge CLK);
			gap(0, n);
			gap(0, n);
			chk_gap("input period", ((c < 3) ? 3 : c) + 1, n);
		end
		// Output decimation for every legal factor, both signals in narrowband
		for (k = 0; k < 4; k++) begin
			c = decs[k];
			bus(1'b1, TCD_OFS_CTRL, 32'h301 | (32'(c) << TCD_POS_DECIM));
			repeat (20) @(posedge CLK);
			gap(1, n);
			chk_gap("decim A", c + 1, n);
			gap(2, n);
			chk_gap("decim B", c + 1, n);
		end
		// Wideband silences the B path
		bus(1'b1, TCD_OFS_CTRL, 32'h0007_0300);
		repeat (10) @(posedge CLK);
		n = 0;
		repeat (64) begin
			@(posedge CLK);
			n += (OUT_VALID_B === 1'b1);
		end
		chk_gap("wideband B pulses", 0, n);
		// Fine phase of B against A for factors 4 and 8
		for (k = 0; k < 2; k++) begin
			f = fines[k];
			bus(1'b1, TCD_OFS_CTRL, 32'h301 | (32'(f) << TCD_POS_DECIM));
			for (c = 0; c <= f; c++) begin
				bus(1'b1, TCD_OFS_DELAY, 32'(c) << TCD_POS_FIN_B);
				repeat (30) @(posedge CLK);
				lag(n);
				chk_gap("fine lag", ((c == f) ? 1 : f + 1 - c) % (f + 1), n);
			end
		end
		// Forced overflow, masking and clearing per filter; random gains may have set flags
		bus(1'b1, TCD_OFS_FLUSH, 32'h0);
		bus(1'b1, TCD_OFS_FLUSH, 32'hF << TCD_POS_FCLR);
		ovf = 0;
		for (k = 0; k < 4; k++) begin
			msk = 4'hF ^ (1 << k);
			bus(1'b1, TCD_OFS_MASK, 32'(msk));
			bus(1'b1, TCD_OFS_FLUSH, 32'h0);
			bus(1'b1, TCD_OFS_FLUSH, 32'h1 << (TCD_POS_FTEST + k));
			ovf |= 1 << k;
			repeat (4) @(posedge CLK);
			bus(1'b0, TCD_OFS_STATUS, 32'h0);
			chk_reg("status", 32'(ovf | (((ovf & msk) != 0) << 4)), q);
			chk_reg("irq masked", 32'h0, {31'h0, IRQ});
			msk = 1 << k;
			bus(1'b1, TCD_OFS_MASK, 32'(msk));
			repeat (3) @(posedge CLK);
			chk_reg("irq", 32'h1, {31'h0, IRQ});
			bus(1'b1, TCD_OFS_FLUSH, 32'h0);
			bus(1'b1, TCD_OFS_FLUSH, 32'h1 << (TCD_POS_FCLR + k));
			ovf = 0;
			repeat (4) @(posedge CLK);
			bus(1'b0, TCD_OFS_STATUS, 32'h0);
			chk_reg("status cleared", 32'(ovf), q);
			chk_reg("irq cleared", 32'h0, {31'h0, IRQ});
		end
		end_of_test();
	end
endmodule // testbench
